// ==== dspr_defs.vh ====
// Constants for the DSI peripheral response logic
`ifndef DSPR_DEFS_VH
`define DSPR_DEFS_VH

// Data types of peripheral-sourced packets
`define DSPR_DT_ACK_ERR 6'h02
`define DSPR_DT_EOTP 6'h08
`define DSPR_DT_LONG_READ 6'h1C
`define DSPR_DT_SHORT_READ1 6'h21
`define DSPR_DT_SHORT_READ2 6'h22

// Trigger bytes in transmit order, bit 0 sent first
`define DSPR_TRIG_ACK 8'h84
`define DSPR_TRIG_TE 8'hBA

// Identifier byte layout
`define DSPR_DI_VC_HI 7
`define DSPR_DI_VC_LO 6
`define DSPR_DI_DT_HI 5
`define DSPR_DI_DT_LO 0

// Error report bit positions
`define DSPR_EB_SOT 0
`define DSPR_EB_SOT_SYNC 1
`define DSPR_EB_EOT_SYNC 2
`define DSPR_EB_ESC 3
`define DSPR_EB_LP_SYNC 4
`define DSPR_EB_TIMEOUT 5
`define DSPR_EB_FALSE_CTL 6
`define DSPR_EB_CONTENTION 7
`define DSPR_EB_ECC_SINGLE 8
`define DSPR_EB_ECC_MULTI 9
`define DSPR_EB_CHECKSUM 10
`define DSPR_EB_DT_UNKNOWN 11
`define DSPR_EB_VC_INVALID 12
`define DSPR_EB_LENGTH 13
`define DSPR_EB_RESERVED 14
`define DSPR_EB_PROTOCOL 15

// Mask of errors that block any access
`define DSPR_ABORT_MASK 16'h9803
// Mask of errors that withhold read data
`define DSPR_NOREAD_MASK 16'h9E17

`define DSPR_ERR_RESET 16'h0000
`define DSPR_BYTE_ZERO 8'h00

`endif

// ==== dspr_ecc.v ====
// Header ECC generator for the 24-bit packet header
`timescale 1ns/1ps
`default_nettype none

module dspr_ecc (
    input wire clk_sys,
    input wire sys_rst,
    input wire [23:0] hdr,
    output reg [7:0] ecc
);

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            ecc <= 8'h00;
        end else begin
            ecc[7] <= 1'b0;
            ecc[6] <= 1'b0;
            ecc[5] <= ^{hdr[10], hdr[11], hdr[12], hdr[13], hdr[14], hdr[15], hdr[16],
                hdr[17], hdr[18], hdr[19], hdr[21], hdr[22], hdr[23]};
            ecc[4] <= ^{hdr[4], hdr[5], hdr[6], hdr[7], hdr[8], hdr[9], hdr[16],
                hdr[17], hdr[18], hdr[19], hdr[20], hdr[22], hdr[23]};
            ecc[3] <= ^{hdr[1], hdr[2], hdr[3], hdr[7], hdr[8], hdr[9], hdr[13],
                hdr[14], hdr[15], hdr[19], hdr[20], hdr[21], hdr[23]};
            ecc[2] <= ^{hdr[0], hdr[2], hdr[3], hdr[5], hdr[6], hdr[9], hdr[11],
                hdr[12], hdr[15], hdr[18], hdr[20], hdr[21], hdr[22]};
            ecc[1] <= ^{hdr[0], hdr[1], hdr[3], hdr[4], hdr[6], hdr[8], hdr[10],
                hdr[12], hdr[14], hdr[17], hdr[20], hdr[21], hdr[22], hdr[23]};
            ecc[0] <= ^{hdr[0], hdr[1], hdr[2], hdr[4], hdr[5], hdr[7], hdr[10],
                hdr[11], hdr[13], hdr[16], hdr[20], hdr[21], hdr[22], hdr[23]};
        end
    end

endmodule
`default_nettype wire

// ==== dspr_response.v ====
// Response side of a DSI peripheral: error register, reply choice, framing
`timescale 1ns/1ps
`default_nettype none
`include "dspr_defs.vh"

module dspr_response #(
    parameter RD_LEN_W = 16
) (
    input wire clk_sys,
    input wire sys_rst,
    input wire [15:0] err_detect,
    input wire cmd_done,
    input wire cmd_is_read,
    input wire cmd_bta,
    input wire [1:0] cmd_vc,
    input wire te_req,
    input wire [RD_LEN_W-1:0] rd_len,
    input wire [7:0] rd_byte,
    input wire lp_clk,
    output reg cmd_exec,
    output reg cmd_drop,
    output reg rd_next,
    output reg [7:0] tx_byte,
    output reg tx_valid,
    output reg tx_trigger,
    output reg tx_bta,
    output reg [15:0] err_reg,
    output reg busy
);

    localparam S_IDLE = 7'b0000001;
    localparam S_TRIG = 7'b0000010;
    localparam S_RDHDR = 7'b0000100;
    localparam S_RDPAY = 7'b0001000;
    localparam S_ERR = 7'b0010000;
    localparam S_BTA = 7'b0100000;
    localparam S_PKT = 7'b1000000;

    // ==========================================================
    // Link clock sampling
    // ==========================================================
    reg lp_clk_m;
    reg lp_clk_s;
    reg lp_clk_d;
    wire byte_en;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            lp_clk_m <= 1'b0;
            lp_clk_s <= 1'b0;
            lp_clk_d <= 1'b0;
        end else begin
            lp_clk_m <= lp_clk;
            lp_clk_s <= lp_clk_m;
            lp_clk_d <= lp_clk_s;
        end
    end
    // One byte leaves per rising link clock edge
    assign byte_en = lp_clk_s & ~lp_clk_d;

    // ==========================================================
    // Helpers
    // ==========================================================
    function [7:0] make_di;
        input [1:0] vc;
        input [5:0] dt;
        begin
            make_di = {vc, dt};
        end
    endfunction

    // ==========================================================
    // Reply state
    // ==========================================================
    reg [6:0] state;
    reg [15:0] rep_err;
    reg [1:0] rep_vc;
    reg send_rep;
    reg [1:0] idx;
    reg [RD_LEN_W-1:0] pay_cnt;
    reg [7:0] di_b;
    reg [7:0] b1;
    reg [7:0] b2;
    reg long_rd;
    reg [2:0] pos;
    wire [7:0] ecc_b;
    wire [15:0] err_all;
    wire [15:0] seen;

    assign seen = err_detect & ~(16'h0001 << `DSPR_EB_RESERVED);
    assign err_all = err_reg | seen;

    dspr_ecc u_ecc (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .hdr({b2, b1, di_b}),
        .ecc(ecc_b)
    );

    // ==========================================================
    // Error register
    // ==========================================================
    wire take_cmd;
    wire rep_taken;
    assign take_cmd = (state == S_IDLE) & cmd_done;
    assign rep_taken = take_cmd & cmd_bta & (err_all != `DSPR_ERR_RESET);

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            err_reg <= `DSPR_ERR_RESET;
        end else if (rep_taken) begin
            // Copied into the reply; only new detections survive
            err_reg <= `DSPR_ERR_RESET;
        end else begin
            err_reg <= err_all;
        end
    end

    // ==========================================================
    // Reply sequencer
    // ==========================================================
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= S_IDLE;
            rep_err <= `DSPR_ERR_RESET;
            rep_vc <= 2'b00;
            send_rep <= 1'b0;
            idx <= 2'd0;
            pay_cnt <= {RD_LEN_W{1'b0}};
            di_b <= `DSPR_BYTE_ZERO;
            b1 <= `DSPR_BYTE_ZERO;
            b2 <= `DSPR_BYTE_ZERO;
            long_rd <= 1'b0;
            pos <= 3'd0;
            cmd_exec <= 1'b0;
            cmd_drop <= 1'b0;
            rd_next <= 1'b0;
            tx_byte <= `DSPR_BYTE_ZERO;
            tx_valid <= 1'b0;
            tx_trigger <= 1'b0;
            tx_bta <= 1'b0;
            busy <= 1'b0;
        end else begin
            cmd_exec <= 1'b0;
            cmd_drop <= 1'b0;
            rd_next <= 1'b0;
            tx_valid <= 1'b0;
            tx_trigger <= 1'b0;
            tx_bta <= 1'b0;
            case (state)
                S_IDLE: begin
                    busy <= 1'b0;
                    if (cmd_done) begin
                        if ((err_all & (`DSPR_ABORT_MASK |
                            (16'h0001 << `DSPR_EB_ECC_MULTI))) != 16'h0000) begin
                            cmd_drop <= 1'b1;
                        end else if (!cmd_is_read) begin
                            cmd_exec <= 1'b1;
                        end
                        rep_vc <= cmd_vc;
                        rep_err <= err_all;
                        send_rep <= (err_all != `DSPR_ERR_RESET);
                        idx <= 2'd0;
                        if (!cmd_bta) begin
                            state <= S_IDLE;
                        end else if (cmd_is_read &&
                            ((err_all & (`DSPR_NOREAD_MASK |
                            (16'h0001 << `DSPR_EB_ECC_MULTI))) == 16'h0000)) begin
                            busy <= 1'b1;
                            long_rd <= (rd_len > 2);
                            pay_cnt <= rd_len;
                            state <= S_RDHDR;
                        end else if (cmd_is_read || err_all != `DSPR_ERR_RESET) begin
                            busy <= 1'b1;
                            state <= S_ERR;
                        end else begin
                            busy <= 1'b1;
                            tx_byte <= `DSPR_TRIG_ACK;
                            state <= S_TRIG;
                        end
                    end else if (te_req) begin
                        busy <= 1'b1;
                        tx_byte <= `DSPR_TRIG_TE;
                        state <= S_TRIG;
                    end
                end
                S_TRIG: begin
                    if (byte_en) begin
                        tx_valid <= 1'b1;
                        tx_trigger <= 1'b1;
                        state <= S_BTA;
                    end
                end
                S_RDHDR: begin
                    if (idx == 2'd0) begin
                        if (long_rd) begin
                            di_b <= make_di(rep_vc, `DSPR_DT_LONG_READ);
                            b1 <= pay_cnt[7:0];
                            b2 <= pay_cnt[15:8];
                            idx <= 2'd3;
                        end else if (pay_cnt == 1) begin
                            di_b <= make_di(rep_vc, `DSPR_DT_SHORT_READ1);
                            b1 <= rd_byte;
                            b2 <= `DSPR_BYTE_ZERO;
                            rd_next <= 1'b1;
                            idx <= 2'd3;
                        end else begin
                            di_b <= make_di(rep_vc, `DSPR_DT_SHORT_READ2);
                            b1 <= rd_byte;
                            rd_next <= 1'b1;
                            idx <= 2'd2;
                        end
                    end else if (idx == 2'd2) begin
                        b2 <= rd_byte;
                        rd_next <= 1'b1;
                        idx <= 2'd3;
                    end else begin
                        idx <= 2'd0;
                        pos <= 3'd0;
                        state <= S_PKT;
                    end
                end
                S_PKT: begin
                    if (pos == 3'd0) begin
                        // Header ECC is registered, so give it one cycle
                        pos <= 3'd1;
                    end else if (byte_en) begin
                        tx_valid <= 1'b1;
                        pos <= pos + 3'd1;
                        case (pos)
                            3'd1: tx_byte <= di_b;
                            3'd2: tx_byte <= b1;
                            3'd3: tx_byte <= b2;
                            default: tx_byte <= ecc_b;
                        endcase
                        if (pos == 3'd4) begin
                            pos <= 3'd0;
                            if (long_rd) begin
                                state <= S_RDPAY;
                            end else if (send_rep) begin
                                state <= S_ERR;
                            end else begin
                                state <= S_BTA;
                            end
                        end
                    end
                end
                S_RDPAY: begin
                    if (byte_en) begin
                        tx_valid <= 1'b1;
                        if (pay_cnt != {RD_LEN_W{1'b0}}) begin
                            tx_byte <= rd_byte;
                            rd_next <= 1'b1;
                            pay_cnt <= pay_cnt - 1'b1;
                        end else begin
                            // No checksum is computed, so the footer is two zero bytes
                            tx_byte <= `DSPR_BYTE_ZERO;
                            pos <= pos + 3'd1;
                            if (pos == 3'd1) begin
                                pos <= 3'd0;
                                long_rd <= 1'b0;
                                state <= send_rep ? S_ERR : S_BTA;
                            end
                        end
                    end
                end
                S_ERR: begin
                    di_b <= make_di(rep_vc, `DSPR_DT_ACK_ERR);
                    b1 <= rep_err[7:0];
                    b2 <= rep_err[15:8];
                    send_rep <= 1'b0;
                    long_rd <= 1'b0;
                    pos <= 3'd0;
                    state <= S_PKT;
                end
                S_BTA: begin
                    tx_bta <= 1'b1;
                    busy <= 1'b0;
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// ==== dspr_response_asserts.sv ====
// Concurrent checks on the ports of the DSI peripheral response block
`timescale 1ns/1ps
`default_nettype none
`include "dspr_defs.vh"
module dspr_response_asserts (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [15:0] err_detect,
    input wire logic cmd_done,
    input wire logic cmd_is_read,
    input wire logic cmd_bta,
    input wire logic cmd_exec,
    input wire logic cmd_drop,
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    input wire logic tx_trigger,
    input wire logic tx_bta,
    input wire logic [15:0] err_reg,
    input wire logic busy
);
    // ==========================================
    // Properties
    localparam logic [15:0] STOP = `DSPR_ABORT_MASK | 16'h0200;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire logic take = cmd_done && !busy;
    wire logic [15:0] seen = err_reg | (err_detect & 16'hBFFF);
    property p_silent;
        take && !cmd_bta |=> (!tx_valid && !tx_bta)[*8];
    endproperty
    a_silent: assert property (p_silent) else $error("reply sent without turnaround");
    property p_ack;
        take && cmd_bta && !cmd_is_read && seen == 16'h0000
            |-> ##[2:40] (tx_valid && tx_trigger && tx_byte == `DSPR_TRIG_ACK);
    endproperty
    a_ack: assert property (p_ack) else $error("no acknowledge trigger");
    property p_bta;
        $rose(busy) |-> ##[1:400] tx_bta;
    endproperty
    a_bta: assert property (p_bta) else $error("bus not handed back");
    property p_busy;
        take && cmd_bta |=> busy;
    endproperty
    a_busy: assert property (p_busy) else $error("turnaround not answered");
    property p_exec;
        take && !cmd_is_read && (seen & STOP) == 16'h0000 |=> cmd_exec && !cmd_drop;
    endproperty
    a_exec: assert property (p_exec) else $error("command not executed");
    property p_drop;
        take && !cmd_is_read && (seen & STOP) != 16'h0000 |=> cmd_drop && !cmd_exec;
    endproperty
    a_drop: assert property (p_drop) else $error("faulty command executed");
    property p_keep;
        !(take && cmd_bta) |=> (err_reg & $past(seen)) == $past(seen);
    endproperty
    a_keep: assert property (p_keep) else $error("error flag lost");
    property p_clear;
        take && cmd_bta |=> err_reg == `DSPR_ERR_RESET;
    endproperty
    a_clear: assert property (p_clear) else $error("reported flags not cleared");
    c_ack: cover property (tx_valid && tx_trigger && tx_byte == `DSPR_TRIG_ACK);
    c_drop: cover property (cmd_drop);
    c_te: cover property (tx_valid && tx_trigger && tx_byte == `DSPR_TRIG_TE);
endmodule
bind dspr_response dspr_response_asserts dspr_response_asserts_i (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .err_detect(err_detect), .cmd_done(cmd_done),
    .cmd_is_read(cmd_is_read), .cmd_bta(cmd_bta), .cmd_exec(cmd_exec), .cmd_drop(cmd_drop),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_trigger(tx_trigger), .tx_bta(tx_bta),
    .err_reg(err_reg), .busy(busy));
`default_nettype wire

// ==== dspr_host_model.sv ====
// Host-side model: link byte clock and capture of reply bytes
`timescale 1ns/1ps
`default_nettype none
module dspr_host_model (
    input wire logic clk_sys,
    input wire logic run,
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    input wire logic tx_bta,
    output logic lp_clk
);
    // ==========================================
    // Link clock and capture
    logic [7:0] got[$];
    int n_bta;
    initial lp_clk = 1'b0;
    // Stands still between replies; a high phase in flight completes first
    always begin
        #62.5;
        if (run || lp_clk) lp_clk = ~lp_clk;
    end
    always @(posedge clk_sys) begin
        if (tx_valid === 1'b1) got.push_back(tx_byte);
        if (tx_bta === 1'b1) n_bta++;
    end
endmodule
`default_nettype wire

// ==== dspr_response_tb_top.sv ====
// Self-checking testbench for the DSI peripheral response block
`timescale 1ns/1ps
`default_nettype none
`include "dspr_defs.vh"
module dspr_response_tb_top;
    // ==========================================
    // Stimulus and monitors
    logic clk_sys, sys_rst, cmd_done, cmd_is_read, cmd_bta, te_req;
    logic [15:0] err_detect, rd_len, e;
    logic [1:0] cmd_vc;
    logic [7:0] rd_byte;
    wire logic lp_clk, cmd_exec, cmd_drop, rd_next, tx_valid, tx_trigger, tx_bta, busy;
    wire logic [7:0] tx_byte;
    wire logic [15:0] err_reg;
    int n_mismatch, comparisons, n_exec, n_drop, n_rdn, base;
    logic [7:0] rd_data [0:1] = '{8'h5A, 8'hC3};
    int stop_bit [5] = '{0, 1, 11, 12, 15};
    int nord_bit [3] = '{2, 4, 10};
    dspr_response dspr_response_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .err_detect(err_detect), .cmd_done(cmd_done), .cmd_is_read(cmd_is_read),
        .cmd_bta(cmd_bta), .cmd_vc(cmd_vc), .te_req(te_req), .rd_len(rd_len),
        .rd_byte(rd_byte), .lp_clk(lp_clk), .cmd_exec(cmd_exec), .cmd_drop(cmd_drop),
        .rd_next(rd_next), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_trigger(tx_trigger),
        .tx_bta(tx_bta), .err_reg(err_reg), .busy(busy));
    dspr_host_model dspr_host_model_i (.clk_sys(clk_sys), .run(busy), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_bta(tx_bta), .lp_clk(lp_clk));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (cmd_exec === 1'b1) n_exec++;
        if (cmd_drop === 1'b1) n_drop++;
    end
    always @(negedge clk_sys) begin
        if (rd_next === 1'b1) n_rdn++;
        rd_byte <= rd_data[(n_rdn - base) & 1];
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic settle();
        int k;
        k = 0;
        repeat (3) @(negedge clk_sys);
        while (busy !== 1'b0 && k < 3000) begin
            @(negedge clk_sys);
            k++;
        end
        if (k == 3000) n_mismatch++;
        repeat (30) @(negedge clk_sys);
    endtask
    // Errors land one cycle ahead of the end of the host transmission
    task automatic xact(input logic rd, input logic bta, input logic [1:0] vc,
                        input logic [15:0] len, input logic [15:0] errs);
        dspr_host_model_i.got.delete();
        dspr_host_model_i.n_bta = 0;
        n_exec = 0;
        n_drop = 0;
        base = n_rdn;
        @(negedge clk_sys);
        err_detect = errs;
        @(negedge clk_sys);
        err_detect = 16'h0000;
        cmd_done = 1'b1;
        cmd_is_read = rd;
        cmd_bta = bta;
        cmd_vc = vc;
        rd_len = len;
        @(negedge clk_sys);
        cmd_done = 1'b0;
        settle();
    endtask
    task automatic find(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i + 2 < dspr_host_model_i.got.size(); i++)
            if (dspr_host_model_i.got[i] === a && dspr_host_model_i.got[i + 1] === b
                && dspr_host_model_i.got[i + 2] === c) hit = 1'b1;
        check(hit, 1);
    endtask
    initial begin
        #200_000;
        n_mismatch++;
        conclude();
    end
    initial begin
        {sys_rst, cmd_done, cmd_is_read, cmd_bta, te_req} = 5'h10;
        {err_detect, rd_len, cmd_vc} = 34'h0;
        repeat (12) @(negedge clk_sys);
        sys_rst = 1'b0;
        xact(0, 1, 2'h1, 16'h0000, 16'h0000);
        check(dspr_host_model_i.got.size(), 1);
        check(dspr_host_model_i.got[0], `DSPR_TRIG_ACK);
        check(n_exec, 1);
        check(dspr_host_model_i.n_bta, 1);
        xact(0, 0, 2'h1, 16'h0000, 16'h0008);
        check(dspr_host_model_i.got.size(), 0);
        check(err_reg, 16'h0008);
        xact(0, 1, 2'h1, 16'h0000, 16'h0100);
        check(n_exec, 1);
        find(8'h42, 8'h08, 8'h01);
        check(err_reg, 16'h0000);
        xact(1, 1, 2'h2, 16'h0001, 16'h0000);
        check(dspr_host_model_i.got[0], 8'hA1);
        check(dspr_host_model_i.got[1], 8'h5A);
        check(dspr_host_model_i.got[2], 8'h00);
        xact(1, 1, 2'h0, 16'h0002, 16'h0100);
        find(8'h22, 8'h5A, 8'hC3);
        find(8'h02, 8'h00, 8'h01);
        check(dspr_host_model_i.got.size(), 8);
        xact(1, 1, 2'h3, 16'h0001, 16'h0200);
        check(dspr_host_model_i.got[0], 8'hC2);
        check(n_rdn - base, 0);
        xact(0, 1, 2'h3, 16'h0000, 16'h0200);
        check(n_drop, 1);
        find(8'hC2, 8'h00, 8'h02);
        check(dspr_host_model_i.got.size(), 4);
        foreach (stop_bit[i]) begin
            e = 16'h0001 << stop_bit[i];
            xact(0, 1, 2'h0, 16'h0000, e);
            check(n_drop, 1);
            check(n_exec, 0);
            find(8'h02, e[7:0], e[15:8]);
        end
        foreach (nord_bit[i]) begin
            e = 16'h0001 << nord_bit[i];
            xact(1, 1, 2'h0, 16'h0001, e);
            check(n_rdn - base, 0);
            find(8'h02, e[7:0], e[15:8]);
        end
        dspr_host_model_i.got.delete();
        te_req = 1'b1;
        @(negedge clk_sys);
        te_req = 1'b0;
        settle();
        check(dspr_host_model_i.got[0], `DSPR_TRIG_TE);
        conclude();
    end
endmodule
`default_nettype wire
